/* verification/rag_gain_loop_sva.sv */
// checker: assertions on the receiver gain loop ports
module rag_gain_loop_sva (
    input wire logic        ref_clk_in,
    input wire logic        reset_n_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic [6:0]  magnitude_in,
    input wire logic        pll_locked_in,
    input wire logic [4:0]  vga_gain_out,
    input wire logic        filter_bypass_out,
    input wire logic        spike_blank_out,
    input wire logic        freeze_out,
    input wire logic        carrier_sense_out
);
    import rag_pkg::*;
    // ========
    // helpers
    logic       wr_ok;
    logic       rd_ok;
    logic       an_wr;
    logic [4:0] max_q;
    logic       rx_q;
    logic       wr_acc;
    logic       en_q;
    assign wr_ok = psel_in && penable_in && pwrite_in && pready_out;
    assign rd_ok = psel_in && penable_in && !pwrite_in && pready_out;
    assign an_wr = psel_in && penable_in && pwrite_in && paddr_in == RAG_OFS_ANALOG;
    assign wr_acc = psel_in && penable_in && pwrite_in && !pready_out;
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            max_q <= 5'h00;
            rx_q  <= 1'b0;
            en_q  <= RAG_RST_GAIN_TWO[RAG_POS_LOOP_EN];
        end else begin
            if (wr_acc && paddr_in == RAG_OFS_GAIN_THREE) begin
                max_q <= pwdata_in[4:0];
            end
            if (wr_acc && paddr_in == RAG_OFS_GAIN_TWO) begin
                en_q <= pwdata_in[RAG_POS_LOOP_EN];
            end
            if (wr_ok && paddr_in == RAG_OFS_RXCTRL) begin
                rx_q <= pwdata_in[RAG_POS_RX_ON];
            end
        end
    end
    // ========
    // assertions
    default clocking @(posedge ref_clk_in);
    endclocking
    default disable iff (!reset_n_in);
    AST_GAIN_UP_ONE: assert property ($past(en_q) && vga_gain_out > $past(vga_gain_out) |->
        vga_gain_out == $past(vga_gain_out) + 5'h01) else $error("gain rose by more than one");
    AST_GAIN_CAP: assert property (vga_gain_out > $past(vga_gain_out) |->
        vga_gain_out <= max_q) else $error("gain above max code");
    AST_STEP_HOLD: assert property ($changed(vga_gain_out) |=> freeze_out [*4])
        else $error("no hold after gain step");
    AST_BLANK_IN_WAIT: assert property (spike_blank_out |-> freeze_out)
        else $error("blanking outside post-step wait");
    AST_SKIP_WRITE: assert property (wr_ok && an_wr |->
        filter_bypass_out == pwdata_in[RAG_POS_SKIP]) else $error("bypass not written");
    AST_SKIP_HOLD: assert property ($changed(filter_bypass_out) |-> $past(an_wr))
        else $error("bypass changed without write");
    AST_CS_READ: assert property (rd_ok && paddr_in == RAG_OFS_STATUS |->
        prdata_out[RAG_POS_CS] == $past(carrier_sense_out, 2)) else $error("status cs wrong");
    AST_STRENGTH_MAX: assert property (rd_ok && paddr_in == RAG_OFS_STRENGTH |->
        prdata_out[6:0] <= RAG_STRENGTH_MAX) else $error("strength out of range");
    AST_RX_FREEZE: assert property (wr_ok && paddr_in == RAG_OFS_RXCTRL &&
        pwdata_in[RAG_POS_RX_ON] && !rx_q |=> ##1 freeze_out [*8]) else $error("no startup hold");
    COV_STEP_UP: cover property (vga_gain_out > $past(vga_gain_out));
    COV_CS: cover property ($rose(carrier_sense_out));
    COV_BLANK: cover property ($rose(spike_blank_out));
endmodule

bind rag_gain_loop rag_gain_loop_sva u_sva (
    .ref_clk_in, .reset_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out, .magnitude_in, .pll_locked_in, .vga_gain_out,
    .filter_bypass_out, .spike_blank_out, .freeze_out, .carrier_sense_out
);

/* verification/rag_host_model.sv */
// partner: host controller model on the apb register port
module rag_host_model #(
    parameter int          SETTLE_CYC = 75000,
    parameter int          GAP_CYC    = 12500,
    parameter logic [11:0] TRIM_ADDR  = 12'h020
) (
    input  wire logic        ref_clk_in,
    output logic             psel_out = 1'b0,
    output logic             penable_out = 1'b0,
    output logic             pwrite_out = 1'b0,
    output logic [11:0]      paddr_out = 12'h000,
    output logic [31:0]      pwdata_out = 32'h0,
    input  wire logic [31:0] prdata_in,
    input  wire logic        pready_in,
    input  wire logic        pslverr_in
);
    timeunit 1ns;
    timeprecision 1ps;
    import rag_pkg::*;
    // ========
    // one transfer, held until pready
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge ref_clk_in);
        psel_out   <= 1'b1;
        pwrite_out <= w;
        paddr_out  <= a;
        pwdata_out <= d;
        @(posedge ref_clk_in);
        penable_out <= 1'b1;
        @(posedge ref_clk_in);
        while (pready_in !== 1'b1) @(posedge ref_clk_in);
        q = prdata_in;
        e = pslverr_in;
        psel_out    <= 1'b0;
        penable_out <= 1'b0;
    endtask
    // ========
    // threshold setup from a reference level
    task automatic derive(input logic [4:0] max_gain);
        logic [31:0] q;
        logic        e;
        xfer(1'b1, RAG_OFS_GAIN_TWO, 32'hBF, q, e);
        xfer(1'b0, RAG_OFS_STRENGTH, 32'h0, q, e);
        xfer(1'b1, RAG_OFS_GAIN_FOUR, q - 32'h8, q, e);
        xfer(1'b1, RAG_OFS_GAIN_TWO, (max_gain > 5'h0A) ? 32'h55 : 32'h45, q, e);
    endtask
    // ========
    // image trim search, trials go to a trim register outside this block
    task automatic trim;
        logic [31:0] q;
        logic        e;
        int          xp, dx, t, sum;
        int          y [5];
        xp = 0;
        dx = 64;
        xfer(1'b1, RAG_OFS_GAIN_TWO, 32'h57, q, e);
        while (dx > 1) begin
            dx = dx / 2;
            for (int k = 0; k < 5; k++) begin
                t = xp + (k - 2) * dx;
                t = (t >= 127) ? 127 : ((t < 0) ? 0 : t);
                xfer(1'b1, TRIM_ADDR, 32'(t), q, e);
                repeat (SETTLE_CYC) @(posedge ref_clk_in);
                sum = 0;
                for (int r = 0; r < 8; r++) begin
                    xfer(1'b0, RAG_OFS_STRENGTH, 32'h0, q, e);
                    sum += int'(q[6:0]);
                    repeat (GAP_CYC) @(posedge ref_clk_in);
                end
                y[k] = sum / 8;
            end
            xp += (y[0] + y[1] > y[3] + y[4]) ? dx : -dx;
            xp = (xp < 0) ? 0 : ((xp > 127) ? 127 : xp);
        end
    endtask
endmodule

/* verification/receiver_agc_loop_test.sv */
// testbench: scenario tasks for the receiver gain loop
module receiver_agc_loop_test;
    timeunit 1ns;
    timeprecision 1ps;
    import rag_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [6:0]  mag = 7'h00;
    logic        locked = 1'b1;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [4:0]  gain;
    logic        bypass, blank, freeze, cs, e;
    int          fails = 0;
    int          n_tests = 0;
    int          i;
    always #20 clk = ~clk;
    rag_host_model #(.SETTLE_CYC(40), .GAP_CYC(8)) host (.ref_clk_in(clk), .psel_out(psel),
        .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata),
        .prdata_in(prdata),
        .pready_in(pready), .pslverr_in(pslverr));
    rag_gain_loop dut (.ref_clk_in(clk), .reset_n_in(rst_n), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .magnitude_in(mag),
        .pll_locked_in(locked), .vga_gain_out(gain), .filter_bypass_out(bypass),
        .spike_blank_out(blank), .freeze_out(freeze), .carrier_sense_out(cs));
    // ========
    // helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [11:0] a);
        host.xfer(1'b0, a, 32'h0, q, e);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, q, e);
    endtask
    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
    endtask
    task automatic cfg(input logic [7:0] thr);
        wr(RAG_OFS_STATUS, 32'h0004_0000);
        wr(RAG_OFS_GAIN_ONE, 32'h0);
        wr(RAG_OFS_GAIN_THREE, 32'h3);
        wr(RAG_OFS_GAIN_FOUR, {24'h0, thr});
        wr(RAG_OFS_RXCTRL, 32'h1);
    endtask
    task automatic held;
        repeat (3) @(posedge clk);
        for (i = 0; i < 280 && freeze === 1'b1; i++) @(posedge clk);
        chk(i, 280);
    endtask
    task automatic results;
        if (fails == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ========
    // scenarios
    task automatic t_regs;
        logic [7:0] rv [5] = '{RAG_RST_GAIN_ONE, RAG_RST_GAIN_TWO, RAG_RST_GAIN_THREE,
                               RAG_RST_GAIN_FOUR, RAG_RST_ANALOG};
        for (int k = 0; k < 5; k++) begin
            rd(12'(4 * k));
            chk(q, {24'h0, rv[k]});
        end
        rd(12'h020);
        chk(q, 32'h0000_0000);
        chk(32'(e), 32'h1);
        wr(12'h002, 32'h1);
        chk(e, 1'b1);
    endtask
    task automatic t_rise;
        cfg(8'h10);
        held;
        for (i = 0; i < 4000 && gain !== 5'h03; i++) @(posedge clk);
        chk(gain, 5'h03);
        repeat (600) @(posedge clk);
        rd(RAG_OFS_STATUS);
        chk(q[12:8], 5'h03);
    endtask
    task automatic t_fall;
        @(posedge clk) mag <= 7'h7F;
        for (i = 0; i < 4000 && gain !== 5'h00; i++) @(posedge clk);
        chk(gain, 5'h00);
        chk(cs, 1'b1);
        rd(RAG_OFS_STATUS);
        chk(q[RAG_POS_CS], 1'b1);
        rd(RAG_OFS_STRENGTH);
        chk(q, 32'h6A);
    endtask
    task automatic t_analog;
        wr(RAG_OFS_ANALOG, 32'h3);
        chk(bypass, 1'b1);
        @(posedge clk) mag <= 7'h00;
        for (i = 0; i < 4000 && blank !== 1'b1; i++) @(posedge clk);
        chk(blank, 1'b1);
        chk(freeze, 1'b1);
        wr(RAG_OFS_ANALOG, 32'h0);
        chk(bypass, 1'b0);
    endtask
    task automatic t_restart;
        repeat (1500) @(posedge clk);
        wr(RAG_OFS_RXCTRL, 32'h0);
        wr(RAG_OFS_RXCTRL, 32'h1);
        held;
        for (i = 0; i < 2000 && freeze !== 1'b0; i++) @(posedge clk);
        chk(freeze, 1'b0);
        @(posedge clk) locked <= 1'b0;
        repeat (4) @(posedge clk);
        locked <= 1'b1;
        repeat (2) @(posedge clk);
        held;
    endtask
    task automatic t_cs_edge;
        do_reset;
        @(posedge clk) mag <= 7'h1E;
        cfg(8'h16);
        repeat (1500) @(posedge clk);
        chk(cs, 1'b0);
        @(posedge clk) mag <= 7'h1F;
        for (i = 0; i < 1500 && cs !== 1'b1; i++) @(posedge clk);
        chk(cs, 1'b1);
        host.derive(5'h03);
        rd(RAG_OFS_GAIN_FOUR);
        chk(q, 32'h17);
        rd(RAG_OFS_GAIN_TWO);
        chk(q, 32'h45);
    endtask
    task automatic t_trim;
        host.trim;
        rd(RAG_OFS_GAIN_TWO);
        chk(q, 32'h57);
        rd(RAG_OFS_STRENGTH);
        chk(q, 32'h1F);
    endtask
    // ========
    // main sequence
    initial begin
        do_reset;
        fork
            begin
                repeat (40000) @(posedge clk);
                fails++;
                results;
            end
        join_none
        t_regs;
        t_rise;
        t_fall;
        t_analog;
        t_restart;
        t_cs_edge;
        t_trim;
        results;
    end
endmodule

/* verilog/rag_gain_loop.sv */
// module: receiver gain control loop with apb registers
//
// The APB register port and the placing of the registers were chosen for this implementation.
module rag_gain_loop
    import rag_pkg::*;
(
    input  wire logic        ref_clk_in,
    input  wire logic        reset_n_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic [6:0]  magnitude_in,
    input  wire logic        pll_locked_in,
    output logic [4:0]       vga_gain_out,
    output logic             filter_bypass_out,
    output logic             spike_blank_out,
    output logic             freeze_out,
    output logic             carrier_sense_out
);
    import rag_pkg::*;
    // ==================================================================
    // state
    // ==================================================================
    typedef struct packed {
        logic [7:0]  r1;
        logic [7:0]  r2;
        logic [7:0]  r3;
        logic [7:0]  r4;
        logic [7:0]  ana;
        logic [2:0]  rxc;
        logic [31:0] rdata;
        logic        ready;
        logic        err;
        logic [11:0] cdiv;
        logic        cen;
        logic [11:0] fdiv_cnt;
        logic [11:0] fdiv;
        logic        fen;
        rag_state_e  st;
        logic [7:0]  wcnt;
        logic [4:0]  gain;
        logic        cs;
        logic        settled;
        logic        rx_prev;
        logic        lock_s1;
        logic        lock_s2;
        logic        lock_prev;
        logic        fsel_prev;
        logic        hyst_pend;
        logic        blank;
        logic [6:0]  strength;
        logic        frz;
    } rag_loop_s;
    rag_loop_s  s_q, s_d;
    logic       avg_start;
    logic       avg_done;
    logic [6:0] avg_val;
    logic [1:0] freeze_sel;
    logic [2:0] wait_sel;
    logic [4:0] max_gain;
    logic [4:0] thresh;
    logic [2:0] up_m;
    logic [2:0] dn_m;
    logic [7:0] lvl_hi;
    logic [7:0] lvl_lo;
    logic       too_hi;
    logic       too_lo;
    logic       sel_ok;
    logic       wr_en;
    logic       rd_en;
    logic       hold_evt;
    // ==================================================================
    // strength averager
    // ==================================================================
    rag_strength_avg u_avg (
        .ref_clk_in         (ref_clk_in),
        .reset_n_in         (reset_n_in),
        .start_in           (avg_start),
        .sample_en_in       (s_q.fen),
        .averaging_length_in(s_q.r2[RAG_POS_AVG +: 2]),
        .magnitude_in       (magnitude_in),
        .done_out           (avg_done),
        .strength_out       (avg_val)
    );
    // ==================================================================
    // next state
    // ==================================================================
    always_comb begin
        freeze_sel = s_q.r1[RAG_POS_FREEZE +: 2];
        wait_sel   = s_q.r1[RAG_POS_WAIT +: 3];
        max_gain   = s_q.r3[RAG_POS_SETTING +: 5];
        thresh     = s_q.r4[RAG_POS_THRESH +: 5];
        up_m       = s_q.r4[RAG_POS_UP +: 3];
        dn_m       = s_q.r3[RAG_POS_DOWN +: 3];
        lvl_hi     = 8'({3'h0, thresh} + RAG_CS_OFFSET + {5'h0, dn_m});
        lvl_lo     = 8'(thresh) - 8'(up_m);
        if (8'(up_m) > 8'(thresh)) begin
            lvl_lo = 8'h00;
        end
        too_hi     = {1'b0, s_q.strength} > lvl_hi;
        too_lo     = {1'b0, s_q.strength} < lvl_lo;
        sel_ok     = (paddr_in[1:0] == 2'h0) && (paddr_in <= RAG_OFS_RXCTRL);
        wr_en      = psel_in && penable_in && pwrite_in && !s_q.ready;
        rd_en      = psel_in && !penable_in && !pwrite_in;
        avg_start  = 1'b0;
        s_d = s_q;
        // converter clock enable from ref clock
        s_d.cen = 1'b0;
        s_d.cdiv = 12'(s_q.cdiv + 12'd1);
        if (s_q.cdiv >= RAG_CONV_DIV - 12'd1) begin
            s_d.cdiv = '0;
            s_d.cen = 1'b1;
        end
        // filter clock enable, divisor gives 2x channel bandwidth
        s_d.fen = 1'b0;
        s_d.fdiv_cnt = 12'(s_q.fdiv_cnt + 12'd1);
        if (s_q.fdiv_cnt >= s_q.fdiv - 12'd1) begin
            s_d.fdiv_cnt = '0;
            s_d.fen = 1'b1;
        end
        // apb slave, one wait state
        s_d.ready = psel_in && penable_in && !s_q.ready;
        s_d.err   = psel_in && penable_in && !s_q.ready && !sel_ok;
        if (wr_en && sel_ok) begin
            case (paddr_in)
                RAG_OFS_GAIN_ONE:   s_d.r1  = pwdata_in[7:0];
                RAG_OFS_GAIN_TWO:   s_d.r2  = pwdata_in[7:0];
                RAG_OFS_GAIN_THREE: s_d.r3  = pwdata_in[7:0];
                RAG_OFS_GAIN_FOUR:  s_d.r4  = pwdata_in[7:0];
                RAG_OFS_ANALOG:     s_d.ana = pwdata_in[7:0];
                RAG_OFS_STATUS:     s_d.fdiv = (pwdata_in[27:16] == 12'h000) ?
                                               12'h001 : pwdata_in[27:16];
                RAG_OFS_RXCTRL:     s_d.rxc = pwdata_in[2:0];
                default:            s_d.rxc = s_q.rxc;
            endcase
        end
        if (rd_en) begin
            case (paddr_in)
                RAG_OFS_GAIN_ONE:   s_d.rdata = {24'h0, s_q.r1};
                RAG_OFS_GAIN_TWO:   s_d.rdata = {24'h0, s_q.r2};
                RAG_OFS_GAIN_THREE: s_d.rdata = {24'h0, s_q.r3};
                RAG_OFS_GAIN_FOUR:  s_d.rdata = {24'h0, s_q.r4};
                RAG_OFS_ANALOG:     s_d.rdata = {24'h0, s_q.ana};
                RAG_OFS_STATUS:     s_d.rdata = {4'h0, s_q.fdiv, 3'h0, s_q.gain, 4'h0,
                                                 s_q.cs, 2'h0, s_q.settled};
                RAG_OFS_STRENGTH:   s_d.rdata = {25'h0, s_q.strength};
                RAG_OFS_RXCTRL:     s_d.rdata = {29'h0, s_q.rxc};
                default:            s_d.rdata = 32'h0000_0000;
            endcase
        end
        // synchronise lock pin and detect hold events
        s_d.lock_s1   = pll_locked_in;
        s_d.lock_s2   = s_q.lock_s1;
        s_d.lock_prev = s_q.lock_s2;
        s_d.rx_prev   = s_q.rxc[RAG_POS_RX_ON];
        s_d.fsel_prev = s_q.rxc[RAG_POS_FSWITCH];
        hold_evt = (s_q.rxc[RAG_POS_RX_ON] && !s_q.rx_prev)
                || (s_q.lock_s2 && !s_q.lock_prev)
                || (s_q.rxc[RAG_POS_FSWITCH] != s_q.fsel_prev)
                || s_q.rxc[RAG_POS_RELOCK];
        if (!(wr_en && sel_ok && paddr_in == RAG_OFS_RXCTRL)) begin
            s_d.rxc[RAG_POS_RELOCK] = 1'b0;
        end
        if (!s_q.rxc[RAG_POS_RX_ON] || !s_q.r2[RAG_POS_LOOP_EN]) begin
            s_d.st = RAG_ST_IDLE;
            s_d.settled = 1'b0;
            if (!s_q.r2[RAG_POS_LOOP_EN]) begin
                s_d.gain = max_gain;
            end
        end else if (hold_evt) begin
            s_d.st = RAG_ST_FREEZE;
            s_d.wcnt = 8'(RAG_FREEZE_BASE << freeze_sel);
            s_d.settled = 1'b0;
        end else begin
            case (s_q.st)
                RAG_ST_IDLE: begin
                    s_d.st = RAG_ST_FREEZE;
                    s_d.wcnt = 8'(RAG_FREEZE_BASE << freeze_sel);
                    s_d.gain = max_gain;
                end
                RAG_ST_FREEZE: begin
                    if (s_q.cen) begin
                        s_d.wcnt = 8'(s_q.wcnt - 8'd1);
                        if (s_q.wcnt <= 8'd1) begin
                            s_d.st = RAG_ST_WAIT;
                            s_d.wcnt = 8'(RAG_WAIT_BASE + RAG_WAIT_STEP * 32'(wait_sel)
                                          + ((wait_sel == 3'h7) ? 32'd4 : 32'd0));
                        end
                    end
                end
                RAG_ST_WAIT: begin
                    if (s_q.fen) begin
                        s_d.wcnt = 8'(s_q.wcnt - 8'd1);
                        if (s_q.blank && s_q.wcnt > 8'd8) begin
                            s_d.wcnt = 8'(s_q.wcnt - 8'd2);
                        end
                        if (s_q.wcnt <= 8'd1) begin
                            s_d.st = RAG_ST_AVG;
                            s_d.blank = 1'b0;
                            avg_start = 1'b1;
                        end
                    end
                end
                RAG_ST_AVG: begin
                    if (avg_done) begin
                        s_d.strength = avg_val;
                        s_d.st = RAG_ST_DECIDE;
                    end
                end
                RAG_ST_DECIDE: begin
                    s_d.cs = s_q.ana[RAG_POS_CS_LATCH] ? s_q.cs :
                             ({1'b0, s_q.strength} > 8'({3'h0, thresh} + RAG_CS_OFFSET));
                    s_d.st = RAG_ST_AVG;
                    avg_start = 1'b1;
                    s_d.settled = 1'b1;
                    if ((too_hi && s_q.gain != 5'h00) || (too_lo && s_q.gain < max_gain)) begin
                        if (s_q.r2[RAG_POS_HYST] && !s_q.hyst_pend) begin
                            s_d.hyst_pend = 1'b1;
                        end else begin
                            s_d.hyst_pend = 1'b0;
                            s_d.gain = too_hi ? 5'(s_q.gain - 5'd1)
                                              : 5'(s_q.gain + 5'd1);
                            s_d.st = RAG_ST_WAIT;
                            s_d.settled = 1'b0;
                            s_d.blank = s_q.ana[RAG_POS_BLANK];
                            avg_start = 1'b0;
                            s_d.wcnt = 8'(RAG_WAIT_BASE + RAG_WAIT_STEP * 32'(wait_sel)
                                          + ((wait_sel == 3'h7) ? 32'd4 : 32'd0));
                        end
                    end else begin
                        s_d.hyst_pend = 1'b0;
                    end
                    if (s_q.gain > max_gain) begin
                        s_d.gain = max_gain;
                    end
                end
                default: s_d.st = RAG_ST_IDLE;
            endcase
        end
        s_d.frz = (s_d.st != RAG_ST_AVG) && (s_d.st != RAG_ST_DECIDE);
    end
    // ==================================================================
    // registers
    // ==================================================================
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            s_q       <= '0;
            s_q.r1    <= RAG_RST_GAIN_ONE;
            s_q.r2    <= RAG_RST_GAIN_TWO;
            s_q.r3    <= RAG_RST_GAIN_THREE;
            s_q.r4    <= RAG_RST_GAIN_FOUR;
            s_q.ana   <= RAG_RST_ANALOG;
            s_q.fdiv  <= RAG_FILT_DIV_RST;
            s_q.st    <= RAG_ST_IDLE;
            s_q.frz   <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end
    // ==================================================================
    // outputs
    // ==================================================================
    assign prdata_out        = s_q.rdata;
    assign pready_out        = s_q.ready;
    assign pslverr_out       = s_q.err;
    assign vga_gain_out      = s_q.gain;
    assign filter_bypass_out = s_q.ana[RAG_POS_SKIP];
    assign spike_blank_out   = s_q.blank;
    assign freeze_out        = s_q.frz;
    assign carrier_sense_out = s_q.cs;
endmodule

/* verilog/rag_pkg.sv */
// package: constants and types for the receiver gain loop
package rag_pkg;
    // ==================================================================
    // register map
    // ==================================================================
    localparam logic [11:0] RAG_OFS_GAIN_ONE   = 12'h000;
    localparam logic [11:0] RAG_OFS_GAIN_TWO   = 12'h004;
    localparam logic [11:0] RAG_OFS_GAIN_THREE = 12'h008;
    localparam logic [11:0] RAG_OFS_GAIN_FOUR  = 12'h00C;
    localparam logic [11:0] RAG_OFS_ANALOG     = 12'h010;
    localparam logic [11:0] RAG_OFS_STATUS     = 12'h014;
    localparam logic [11:0] RAG_OFS_STRENGTH   = 12'h018;
    localparam logic [11:0] RAG_OFS_RXCTRL     = 12'h01C;
    // ==================================================================
    // field positions
    // ==================================================================
    localparam int RAG_POS_WAIT      = 0;
    localparam int RAG_POS_FREEZE    = 3;
    localparam int RAG_POS_AVG       = 0;
    localparam int RAG_POS_HYST      = 2;
    localparam int RAG_POS_LOOP_EN   = 6;
    localparam int RAG_POS_DOWN      = 5;
    localparam int RAG_POS_UP        = 5;
    localparam int RAG_POS_SETTING   = 0;
    localparam int RAG_POS_THRESH    = 0;
    localparam int RAG_POS_BLANK     = 0;
    localparam int RAG_POS_SKIP      = 1;
    localparam int RAG_POS_CS_LATCH  = 2;
    localparam int RAG_POS_CS        = 3;
    localparam int RAG_POS_SETTLED   = 0;
    localparam int RAG_POS_RX_ON     = 0;
    localparam int RAG_POS_RELOCK    = 1;
    localparam int RAG_POS_FSWITCH   = 2;
    // ==================================================================
    // reset values
    // ==================================================================
    localparam logic [7:0] RAG_RST_GAIN_ONE   = 8'h00;
    localparam logic [7:0] RAG_RST_GAIN_TWO   = 8'h55;
    localparam logic [7:0] RAG_RST_GAIN_THREE = 8'h00;
    localparam logic [7:0] RAG_RST_GAIN_FOUR  = 8'h00;
    localparam logic [7:0] RAG_RST_ANALOG     = 8'h00;
    // ==================================================================
    // timing and limits
    // ==================================================================
    localparam int          RAG_FREEZE_BASE   = 16;
    localparam int          RAG_WAIT_BASE     = 16;
    localparam int          RAG_WAIT_STEP     = 32'd4;
    localparam logic [6:0]  RAG_CS_OFFSET     = 7'h08;
    localparam logic [6:0]  RAG_STRENGTH_MAX  = 7'h6A;
    localparam int          RAG_BLANK_SAMPLES = 1;
    localparam int          RAG_STEP_DB       = 3;
    localparam logic [31:0] RAG_REF_CLK_HZ    = 32'd25000000;
    localparam logic [31:0] RAG_CONV_CLK_HZ   = 32'd1228800;
    localparam logic [11:0] RAG_CONV_DIV      = 12'(RAG_REF_CLK_HZ / RAG_CONV_CLK_HZ);
    localparam logic [11:0] RAG_FILT_DIV_RST  = 12'd1000;
    typedef enum logic [4:0] {
        RAG_ST_IDLE   = 5'b00001,
        RAG_ST_FREEZE = 5'b00010,
        RAG_ST_WAIT   = 5'b00100,
        RAG_ST_AVG    = 5'b01000,
        RAG_ST_DECIDE = 5'b10000
    } rag_state_e;
endpackage

/* verilog/rag_strength_avg.sv */
// module: log-magnitude averager producing the signal strength value
module rag_strength_avg
    import rag_pkg::*;
(
    input  wire logic       ref_clk_in,
    input  wire logic       reset_n_in,
    input  wire logic       start_in,
    input  wire logic       sample_en_in,
    input  wire logic [1:0] averaging_length_in,
    input  wire logic [6:0] magnitude_in,
    output logic            done_out,
    output logic [6:0]      strength_out
);
    import rag_pkg::*;
    // ==================================================================
    // state
    // ==================================================================
    typedef struct packed {
        logic [10:0] acc;
        logic [4:0]  cnt;
        logic        busy;
        logic        done;
        logic [6:0]  res;
    } rag_avg_s;
    rag_avg_s s_q, s_d;
    logic [4:0] len;
    always_comb begin
        len = 5'(5'd2 << averaging_length_in);
        s_d = s_q;
        s_d.done = 1'b0;
        if (start_in) begin
            s_d.acc  = '0;
            s_d.cnt  = '0;
            s_d.busy = 1'b1;
        end else if (s_q.busy && sample_en_in) begin
            s_d.acc = 11'(s_q.acc + {4'h0, magnitude_in});
            s_d.cnt = 5'(s_q.cnt + 5'd1);
            if (5'(s_q.cnt + 5'd1) == len) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
                s_d.res  = 7'((11'(s_q.acc + {4'h0, magnitude_in}))
                               >> (3'(averaging_length_in) + 3'd1));
                if (s_d.res > RAG_STRENGTH_MAX) begin
                    s_d.res = RAG_STRENGTH_MAX;
                end
            end
        end
    end
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign done_out     = s_q.done;
    assign strength_out = s_q.res;
endmodule
